// ### core/asp_pkg.sv
/*
 * Constants, field layouts and carrier types of the async serial port.
 * Assumes one clock domain (pclk) and register access over APB.
 */
`default_nettype none
package asp_pkg;
  // Word base of the register frame; bus byte address is four times the index
  localparam logic [15:0] ASP_WORD_BASE = 16'h7050;
  localparam logic [5:0] IDX_CCR   = 6'h00;
  localparam logic [5:0] IDX_CTL1  = 6'h01;
  localparam logic [5:0] IDX_HBAUD = 6'h02;
  localparam logic [5:0] IDX_LBAUD = 6'h03;
  localparam logic [5:0] IDX_CTL2  = 6'h04;
  localparam logic [5:0] IDX_RXST  = 6'h05;
  localparam logic [5:0] IDX_RXEMU = 6'h06;
  localparam logic [5:0] IDX_RXBUF = 6'h07;
  localparam logic [5:0] IDX_TXBUF = 6'h09;
  localparam logic [5:0] IDX_FFTX  = 6'h0A;
  localparam logic [5:0] IDX_FFRX  = 6'h0B;
  localparam logic [5:0] IDX_FFCT  = 6'h0C;
  localparam logic [5:0] IDX_IST   = 6'h10;
  localparam logic [5:0] IDX_IMASK = 6'h11;
  // Bit positions
  localparam int CTL1_RXEN = 0;
  localparam int CTL1_TXEN = 1;
  localparam int CTL1_SLEEP = 2;
  localparam int CTL1_TXWAKE = 3;
  localparam int CTL2_TXIE = 0;
  localparam int CTL2_RXIE = 1;
  localparam int CTL2_TXEMPTY = 6;
  localparam int CTL2_TX_BUFFER_READY_FLAG = 7;
  localparam int FFCT_FIFOEN = 0;
  localparam int FFCT_ABDEN = 1;
  localparam int FFCT_ABDDONE = 7;
  // Interrupt status / mask bits
  localparam int IS_TX_BUFFER_READY_FLAG = 0;
  localparam int IS_RX_BUFFER_READY_FLAG = 1;
  localparam int IS_RXERR = 2;
  localparam int IS_BRK = 3;
  localparam int IS_TXEMPTY = 4;
  localparam int IS_W = 5;
  // Reset values
  localparam logic [7:0]  CCR_RST = 8'h07;
  localparam logic [15:0] DIV_RST = 16'h0000;
  // Timing counts in oversample ticks / bits
  localparam logic [2:0] OVS_LAST = 3'h7;
  localparam logic [2:0] SAMPLE_TICK = 3'h3;
  localparam logic [6:0] IDLE_TICKS = 7'h50;
  localparam logic [3:0] GAP_LAST = 4'hA;
  localparam int FIFO_DEPTH = 16;

  typedef struct packed {
    logic       stop2;
    logic       even;
    logic       par_en;
    logic       rsvd;
    logic       addr_mode;
    logic [2:0] len_m1;
  } asp_ccr_t;

  typedef struct packed {
    logic       brk;
    logic       fe;
    logic       pe;
    logic       wake;
    logic [7:0] data;
  } asp_rxent_t;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000, TX_GAP = 3'b001, TX_START = 3'b010, TX_DATA = 3'b011,
    TX_ADDR = 3'b100, TX_PAR = 3'b101, TX_STOP = 3'b110
  } asp_tx_st_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b010, RX_ADDR = 3'b011,
    RX_PAR = 3'b100, RX_STOP = 3'b101, RX_LOW = 3'b110
  } asp_rx_st_t;
endpackage
`default_nettype wire

// ### core/asp_fifo.sv
/*
 * Small FIFO memory with registered show-ahead read data.
 * Assumes the owner never writes when full nor reads when empty.
 */
`default_nettype none
module asp_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // Write side
  input  wire logic                       wr_en,
  input  wire logic [W-1:0]               wr_data,
  // Read side
  input  wire logic                       rd_en,
  output logic      [W-1:0]               rd_data,
  output logic      [$clog2(DEPTH):0]     count
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  wire  [AW-1:0] rd_ptr_nxt = rd_en ? rd_ptr_r + 1'b1 : rd_ptr_r;

  // Storage array
  always_ff @(posedge pclk) begin
    if (wr_en) mem[wr_ptr_r] <= wr_data;
  end

  // Pointers, level and head register with write bypass
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count    <= '0;
      rd_data  <= '0;
    end else begin
      wr_ptr_r <= wr_en ? wr_ptr_r + 1'b1 : wr_ptr_r;
      rd_ptr_r <= rd_ptr_nxt;
      count    <= count + (AW+1)'(wr_en) - (AW+1)'(rd_en);
      rd_data  <= (wr_en && wr_ptr_r == rd_ptr_nxt) ? wr_data : mem[rd_ptr_nxt];
    end
  end
endmodule // asp_fifo
`default_nettype wire

// ### core/asp_baud.sv
/*
 * Oversample tick generator, eight ticks per bit.
 * Assumes divisor is a quasi-static software setting.
 */
`default_nettype none
module asp_baud (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Divisor and tick
  input  wire logic [15:0] divisor,
  output logic             tick
);
  logic [15:0] cnt_r;
  // Tick every max(divisor,1)+1 cycles: bit = 8*(d+1), or 16 when d is zero
  wire  [15:0] top = (divisor == 16'h0000) ? 16'h0001 : divisor;

  // Divider counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else begin
      tick  <= (cnt_r >= top);
      cnt_r <= (cnt_r >= top) ? 16'h0000 : cnt_r + 16'h0001;
    end
  end
endmodule // asp_baud
`default_nettype wire

// ### core/asp_serial_port.sv
/*
 * Async serial port: APB registers, double-buffered transmitter and receiver,
 * optional 16-entry FIFOs, wake-up modes, auto-baud, interrupt status.
 * Assumes pclk is the low speed peripheral clock and the rx pin is asynchronous.
 */
// Contract
// - Tx and rx each have holding buffer, shift register, enable and interrupt enable.
// - Transmitter and receiver run independently or together.
// - Line bits are plain NRZ levels.
// - Received frames checked for break, parity, overrun, framing; four flags.
// - Bit rate from a 16-bit divisor.
// - Rate is clock/(8*(d+1)), or clock/16 when divisor is zero.
// - One start bit, then one to eight data bits.
// - Even, odd or no parity after data.
// - One or two stop bits.
// - Idle-line and address-bit multiprocessor wake-up schemes.
// - Tx buffer ready flag and tx empty flag.
// - Rx ready, break and summary rx error flags.
// - Separate tx and rx interrupt enables; break is not gated.
// - Register frame begins at its fixed word base.
// - Registers are 8 bits; upper bits read zero, writes there ignored.
// - Auto-baud detection and 16-entry tx and rx FIFOs.
`default_nettype none
module asp_serial_port
  import asp_pkg::*;
#(
  parameter int FIFO_DEPTH_P = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial pins
  input  wire logic        serial_rx_pin,
  output logic             serial_tx_pin,
  // Interrupt
  output logic             irq
);
  localparam int CW = $clog2(FIFO_DEPTH_P) + 1;

  // Register index decode, used only by the error answer; the read mux decodes on its own
  function automatic logic is_mapped(input logic [5:0] i);
    case (i)
      IDX_CCR, IDX_CTL1, IDX_HBAUD, IDX_LBAUD, IDX_CTL2, IDX_RXST, IDX_RXEMU,
      IDX_RXBUF, IDX_TXBUF, IDX_FFTX, IDX_FFRX, IDX_FFCT, IDX_IST, IDX_IMASK: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  asp_ccr_t         ccr_r;
  logic [7:0]       ctl1_r;
  logic [1:0]       ie_r;
  logic [15:0]      div_r;
  logic [3:0]       err_r;       // brk, fe, oe, pe
  logic             rxwake_r;
  logic             txwake_r;
  logic             fifo_en_r;
  logic             abd_en_r;
  logic             abd_done_r;
  logic [18:0]      abd_cnt_r;
  logic [IS_W-1:0]  ist_r;
  logic [IS_W-1:0]  imask_r;
  logic             tick;
  logic             rx_m_r;
  logic             rx_s_r;
  logic [7:0]       rd_val;

  // Bus decode
  wire [5:0] idx    = paddr[7:2];
  wire       acc    = psel && penable && pready;
  wire       wr     = acc && pwrite;
  wire       rd     = acc && !pwrite;
  wire [7:0] wd     = pwdata[7:0];
  wire       w_ccr  = wr && idx == IDX_CCR;
  wire       w_ctl1 = wr && idx == IDX_CTL1;
  wire       w_hb   = wr && idx == IDX_HBAUD;
  wire       w_lb   = wr && idx == IDX_LBAUD;
  wire       w_ctl2 = wr && idx == IDX_CTL2;
  wire       w_rxst = wr && idx == IDX_RXST;
  wire       w_tx   = wr && idx == IDX_TXBUF;
  wire       w_ffct = wr && idx == IDX_FFCT;
  wire       w_ist  = wr && idx == IDX_IST;
  wire       w_imsk = wr && idx == IDX_IMASK;
  wire       r_rxb  = rd && idx == IDX_RXBUF;
  wire       rx_en  = ctl1_r[CTL1_RXEN];
  wire       tx_en  = ctl1_r[CTL1_TXEN];

  // FIFO capacity: one entry as plain holding buffer, full depth in FIFO mode
  wire [CW-1:0] cap = fifo_en_r ? CW'(FIFO_DEPTH_P) : CW'(1);
  logic [CW-1:0] tx_cnt;
  logic [CW-1:0] rx_cnt;
  logic [7:0]    tx_head;
  logic [$bits(asp_rxent_t)-1:0] rx_head_v;
  wire asp_rxent_t rx_head = asp_rxent_t'(rx_head_v);
  wire tx_full  = tx_cnt >= cap;
  wire rx_full  = rx_cnt >= cap;
  wire rx_rdy   = rx_cnt != '0;
  wire tx_push  = w_tx && !tx_full;
  wire rx_pop   = r_rxb && rx_rdy;
  logic tx_pop;
  logic rx_push;
  asp_rxent_t rx_ent;

  asp_fifo #(.W(8), .DEPTH(FIFO_DEPTH_P)) u_txq (
    .pclk(pclk), .presetn(presetn), .wr_en(tx_push), .wr_data(wd),
    .rd_en(tx_pop), .rd_data(tx_head), .count(tx_cnt));
  asp_fifo #(.W($bits(asp_rxent_t)), .DEPTH(FIFO_DEPTH_P)) u_rxq (
    .pclk(pclk), .presetn(presetn), .wr_en(rx_push), .wr_data(rx_ent),
    .rd_en(rx_pop), .rd_data(rx_head_v), .count(rx_cnt));
  asp_baud u_baud (.pclk(pclk), .presetn(presetn), .divisor(div_r), .tick(tick));

  // ---------------- Transmitter ----------------
  asp_tx_st_t tx_st_r;
  logic [2:0] tx_tc_r;
  logic [3:0] tx_bit_r;
  logic [7:0] tx_sh_r;
  logic       tx_par_r;
  logic       tx_ab_r;
  logic       tx_line;
  wire        tx_bend  = tick && tx_tc_r == OVS_LAST;
  wire        tx_empty = tx_st_r == TX_IDLE && tx_cnt == '0;
  wire        tx_start = tx_st_r == TX_IDLE && tx_en && tx_cnt != '0;
  assign tx_pop = tx_start;

  // Line level per state
  always_comb begin
    case (tx_st_r)
      TX_START: tx_line = 1'b0;
      TX_DATA:  tx_line = tx_sh_r[0];
      TX_ADDR:  tx_line = tx_ab_r;
      TX_PAR:   tx_line = tx_par_r ^ ~ccr_r.even;
      default:  tx_line = 1'b1;
    endcase
  end

  // Transmit sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_r <= TX_IDLE;
      tx_tc_r <= '0;
      tx_bit_r <= '0;
      tx_sh_r <= '0;
      tx_par_r <= 1'b0;
      tx_ab_r <= 1'b0;
    end else begin
      if (tick && tx_st_r != TX_IDLE) tx_tc_r <= tx_tc_r + 3'h1;
      case (tx_st_r)
        TX_IDLE: begin
          tx_tc_r <= '0;
          tx_bit_r <= '0;
          if (tx_start) begin
            tx_sh_r  <= tx_head;
            tx_par_r <= 1'b0;
            tx_ab_r  <= txwake_r;
            tx_st_r  <= (txwake_r && !ccr_r.addr_mode) ? TX_GAP : TX_START;
          end
        end
        TX_GAP: if (tx_bend) begin
          tx_bit_r <= (tx_bit_r == GAP_LAST) ? 4'h0 : tx_bit_r + 4'h1;
          if (tx_bit_r == GAP_LAST) tx_st_r <= TX_START;
        end
        TX_START: if (tx_bend) tx_st_r <= TX_DATA;
        TX_DATA: if (tx_bend) begin
          tx_sh_r  <= {1'b0, tx_sh_r[7:1]};
          tx_par_r <= tx_par_r ^ tx_sh_r[0];
          tx_bit_r <= tx_bit_r + 4'h1;
          if (tx_bit_r[2:0] == ccr_r.len_m1) begin
            tx_bit_r <= '0;
            tx_st_r  <= ccr_r.addr_mode ? TX_ADDR : (ccr_r.par_en ? TX_PAR : TX_STOP);
          end
        end
        TX_ADDR: if (tx_bend) begin
          tx_par_r <= tx_par_r ^ tx_ab_r;
          tx_st_r  <= ccr_r.par_en ? TX_PAR : TX_STOP;
        end
        TX_PAR: if (tx_bend) tx_st_r <= TX_STOP;
        TX_STOP: if (tx_bend) begin
          tx_bit_r <= 4'h1;
          if (!(ccr_r.stop2 && tx_bit_r == 4'h0)) tx_st_r <= TX_IDLE;
        end
        default: tx_st_r <= TX_IDLE;
      endcase
    end
  end

  // ---------------- Receiver ----------------
  asp_rx_st_t rx_st_r;
  logic [2:0] rx_tc_r;
  logic [3:0] rx_bit_r;
  logic [7:0] rx_sh_r;
  logic       rx_par_r;
  logic       rx_pbit_r;
  logic       rx_pe_r;
  logic       rx_ab_r;
  logic       rx_gap_r;
  logic       idle_seen_r;
  logic [6:0] idle_cnt_r;
  wire        samp   = tick && rx_tc_r == SAMPLE_TICK;
  wire        at_stop = samp && rx_st_r == RX_STOP;
  wire [7:0]  rx_data = rx_sh_r >> (3'h7 - ccr_r.len_m1);
  wire        rx_fe   = !rx_s_r;
  wire        rx_brk  = rx_fe && rx_sh_r == 8'h00 && !rx_ab_r && !rx_pbit_r;
  wire        wake    = !ctl1_r[CTL1_SLEEP] || (ccr_r.addr_mode ? rx_ab_r : rx_gap_r);
  wire        rx_take = at_stop && rx_en && wake;
  wire        rx_oe   = rx_take && rx_full;
  assign rx_push = rx_take && !rx_full;
  assign rx_ent  = '{brk: rx_brk, fe: rx_fe, pe: rx_pe_r, wake: rx_ab_r | rx_gap_r, data: rx_data};

  // Pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_m_r <= 1'b1;
      rx_s_r <= 1'b1;
    end else begin
      rx_m_r <= serial_rx_pin;
      rx_s_r <= rx_m_r;
    end
  end

  // Idle-line detector: ten idle bit times arm the next frame as a wake frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_cnt_r <= '0;
      idle_seen_r <= 1'b0;
    end else if (rx_st_r != RX_IDLE || !rx_s_r) begin
      idle_cnt_r <= '0;
      if (rx_st_r == RX_START) idle_seen_r <= 1'b0;
    end else if (tick && idle_cnt_r != IDLE_TICKS) begin
      idle_cnt_r <= idle_cnt_r + 7'h01;
    end else if (idle_cnt_r == IDLE_TICKS) begin
      idle_seen_r <= 1'b1;
    end
  end

  // Receive sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_r <= RX_IDLE;
      rx_tc_r <= '0;
      rx_bit_r <= '0;
      rx_sh_r <= '0;
      rx_par_r <= 1'b0;
      rx_pbit_r <= 1'b0;
      rx_pe_r <= 1'b0;
      rx_ab_r <= 1'b0;
      rx_gap_r <= 1'b0;
    end else begin
      if (tick && rx_st_r != RX_IDLE) rx_tc_r <= rx_tc_r + 3'h1;
      case (rx_st_r)
        RX_IDLE: begin
          rx_tc_r <= '0;
          if (rx_en && !rx_s_r) begin
            rx_st_r  <= RX_START;
            rx_gap_r <= idle_seen_r;
          end
        end
        RX_START: if (samp) begin
          rx_st_r   <= rx_s_r ? RX_IDLE : RX_DATA;
          rx_bit_r  <= '0;
          rx_sh_r   <= '0;
          rx_par_r  <= 1'b0;
          rx_pbit_r <= 1'b0;
          rx_pe_r   <= 1'b0;
          rx_ab_r   <= 1'b0;
        end
        RX_DATA: if (samp) begin
          rx_sh_r  <= {rx_s_r, rx_sh_r[7:1]};
          rx_par_r <= rx_par_r ^ rx_s_r;
          rx_bit_r <= rx_bit_r + 4'h1;
          if (rx_bit_r[2:0] == ccr_r.len_m1)
            rx_st_r <= ccr_r.addr_mode ? RX_ADDR : (ccr_r.par_en ? RX_PAR : RX_STOP);
        end
        RX_ADDR: if (samp) begin
          rx_ab_r  <= rx_s_r;
          rx_par_r <= rx_par_r ^ rx_s_r;
          rx_st_r  <= ccr_r.par_en ? RX_PAR : RX_STOP;
        end
        RX_PAR: if (samp) begin
          rx_pbit_r <= rx_s_r;
          rx_pe_r   <= rx_s_r ^ rx_par_r ^ ~ccr_r.even;
          rx_st_r   <= RX_STOP;
        end
        RX_STOP: if (samp) rx_st_r <= rx_s_r ? RX_IDLE : RX_LOW;
        RX_LOW: if (rx_s_r) rx_st_r <= RX_IDLE;
        default: rx_st_r <= RX_IDLE;
      endcase
    end
  end

  // ---------------- Registers ----------------
  // Receive error flags: hardware set wins over write-one-to-clear
  wire [3:0] err_set = rx_take ? {rx_brk, rx_fe, rx_oe, rx_pe_r} : 4'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_r    <= '0;
      rxwake_r <= 1'b0;
    end else begin
      err_r    <= (err_r & ~(w_rxst ? wd[5:2] : 4'h0)) | err_set;
      rxwake_r <= rx_push ? rx_ent.wake : (rx_pop ? 1'b0 : rxwake_r);
    end
  end

  // Control, baud and auto-baud
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ccr_r <= asp_ccr_t'(CCR_RST);
      ctl1_r <= '0;
      ie_r <= '0;
      div_r <= DIV_RST;
      txwake_r <= 1'b0;
      fifo_en_r <= 1'b0;
      abd_en_r <= 1'b0;
      abd_done_r <= 1'b0;
      abd_cnt_r <= '0;
      imask_r <= '0;
    end else begin
      if (w_ccr) ccr_r <= asp_ccr_t'(wd);
      if (w_ctl1) ctl1_r <= wd;
      if (w_ctl2) ie_r <= wd[1:0];
      if (w_hb) div_r[15:8] <= wd;
      if (w_lb) div_r[7:0] <= wd;
      if (w_imsk) imask_r <= wd[IS_W-1:0];
      txwake_r <= (w_ctl1 && wd[CTL1_TXWAKE]) || (txwake_r && !tx_start);
      if (w_ffct) begin
        fifo_en_r  <= wd[FFCT_FIFOEN];
        abd_en_r   <= wd[FFCT_ABDEN];
        abd_done_r <= 1'b0;
        abd_cnt_r  <= '0;
      end else if (abd_en_r && !abd_done_r) begin
        // Width of one low bit in clocks sets the divisor
        if (!rx_s_r && abd_cnt_r != '1) abd_cnt_r <= abd_cnt_r + 19'h00001;
        if (rx_s_r && abd_cnt_r != '0) begin
          div_r <= (abd_cnt_r[18:3] == 16'h0000) ? 16'h0000 : abd_cnt_r[18:3] - 16'h0001;
          abd_done_r <= 1'b1;
        end
      end
    end
  end

  // Interrupt events, enables per direction, break always passes
  logic tx_empty_d_r;
  wire [IS_W-1:0] ev = {tx_empty && !tx_empty_d_r && ie_r[CTL2_TXIE],
                        rx_take && rx_brk,
                        rx_take && (rx_fe || rx_oe || rx_pe_r) && ie_r[CTL2_RXIE],
                        rx_push && ie_r[CTL2_RXIE],
                        tx_pop && ie_r[CTL2_TXIE]};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_r <= '0;
      tx_empty_d_r <= 1'b1;
      irq <= 1'b0;
    end else begin
      tx_empty_d_r <= tx_empty;
      ist_r <= (ist_r & ~(w_ist ? wd[IS_W-1:0] : '0)) | ev;
      irq <= |(ist_r & imask_r);
    end
  end

  // Read mux, upper bits are zero
  always_comb begin
    case (idx)
      IDX_CCR:   rd_val = ccr_r;
      IDX_CTL1:  rd_val = {ctl1_r[7:4], txwake_r, ctl1_r[2:0]};
      IDX_HBAUD: rd_val = div_r[15:8];
      IDX_LBAUD: rd_val = div_r[7:0];
      IDX_CTL2:  rd_val = {!tx_full, tx_empty, 4'h0, ie_r};
      IDX_RXST:  rd_val = {|err_r, rx_rdy, err_r, rxwake_r, 1'b0};
      IDX_RXEMU, IDX_RXBUF: rd_val = rx_head.data;
      IDX_FFTX:  rd_val = 8'(tx_cnt);
      IDX_FFRX:  rd_val = 8'(rx_cnt);
      IDX_FFCT:  rd_val = {abd_done_r, 5'h00, abd_en_r, fifo_en_r};
      IDX_IST:   rd_val = 8'(ist_r);
      IDX_IMASK: rd_val = 8'(imask_r);
      default:   rd_val = 8'h00;
    endcase
  end

  // APB answer one cycle into the access phase; line output registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
      serial_tx_pin <= 1'b1;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !is_mapped(idx);
      prdata  <= (psel && penable && !pready && !pwrite) ? {24'h000000, rd_val} : 32'h00000000;
      serial_tx_pin <= tx_line;
    end
  end
endmodule // asp_serial_port
`default_nettype wire

// ### verif/asp_port_checker.sv
/*
 * Checker for the async serial port: APB answer timing and line timing.
 * Assumes it is bound to asp_serial_port and sees only its ports.
 */
`default_nettype none
module asp_port_checker
  import asp_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Line and interrupt
  input wire logic        serial_rx_pin,
  input wire logic        serial_tx_pin,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Bus answer
  a_ready_after_access: assert property ($rose(penable) && psel |=> pready)
    else $error("pready late");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready too long");
  a_err_with_ready: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr alone");
  a_unmapped_err: assert property (pready && paddr[7:2] == 6'h08 |-> pslverr)
    else $error("unmapped index accepted");
  a_mapped_no_err: assert property (pready && paddr[7:2] == IDX_CCR |-> !pslverr)
    else $error("mapped index refused");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_write_reads_zero: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("read data on write");
  // Line timing: a bit is checked to last at least eight clocks
  a_start_low: assert property ($fell(serial_tx_pin) |-> !serial_tx_pin [*8])
    else $error("start bit short");
  a_bit_stable: assert property ($changed(serial_tx_pin) |=> $stable(serial_tx_pin) [*8])
    else $error("line bit short");
  c_slverr: cover property (pready && pslverr);
  c_tx_frame: cover property ($fell(serial_tx_pin));
  c_irq: cover property ($rose(irq));
endmodule // asp_port_checker

bind asp_serial_port asp_port_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .serial_rx_pin(serial_rx_pin),
  .serial_tx_pin(serial_tx_pin), .irq(irq));
`default_nettype wire

// ### verif/asp_peer.sv
/*
 * Far-side serial peer: sends frames to the port and captures its frames.
 * Assumes eight data bits, one parity bit and one stop bit per frame.
 */
`default_nettype none
module asp_peer (
  // Clock
  input  wire logic pclk,
  // Line
  input  wire logic tx_line,
  output var logic  rx_line
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rx_line = 1'b1; // Idle high

  // Send one frame, bc clocks per bit
  task automatic send(input logic [7:0] d, input int bc, input logic odd, input logic low_stop);
    rx_line <= 1'b0;
    repeat (bc) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      rx_line <= d[i];
      repeat (bc) @(posedge pclk);
    end
    rx_line <= ^d ^ odd;
    repeat (bc) @(posedge pclk);
    rx_line <= ~low_stop;
    repeat (bc) @(posedge pclk);
    rx_line <= 1'b1;
    repeat (bc) @(posedge pclk);
  endtask

  // Capture start, data, parity and stop at bit centres
  task automatic get(input int bc, output logic [10:0] f);
    @(negedge tx_line);
    repeat (bc / 2) @(posedge pclk);
    for (int i = 0; i < 11; i++) begin
      f[i] = tx_line;
      repeat (bc) @(posedge pclk);
    end
  endtask
endmodule // asp_peer
`default_nettype wire

// ### verif/tb.sv
/*
 * Self-checking bench for the async serial port.
 * Assumes the peer model on the line and APB register access.
 */
`default_nettype none
module tb
  import asp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, serial_rx_pin, serial_tx_pin, irq, err;
  int          miscompares = 0, checked = 0;

  always #2 pclk = ~pclk;

  asp_serial_port DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_rx_pin(serial_rx_pin), .serial_tx_pin(serial_tx_pin), .irq(irq));
  asp_peer u_peer (.pclk(pclk), .tx_line(serial_tx_pin), .rx_line(serial_rx_pin));

  // One APB transfer, entered and left at a rising edge
  task automatic bus(input logic w, input logic [5:0] idx, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic rdchk(input logic [5:0] idx, input logic [31:0] e);
    bus(1'b0, idx, 32'h0);
    chk(rd, e);
  endtask

  task automatic t_regs;
    rdchk(IDX_CCR, {24'h0, CCR_RST});
    bus(1'b1, IDX_CCR, 32'hABCD_FF67);
    rdchk(IDX_CCR, 32'h67);
    bus(1'b0, 6'h08, 32'h0);
    chk(err, 1'b1);
    bus(1'b1, IDX_HBAUD, 32'h81);
    rdchk(IDX_HBAUD, 32'h81);
    bus(1'b1, IDX_HBAUD, 32'h0);
    bus(1'b1, IDX_LBAUD, 32'h1234_5603);
    rdchk(IDX_LBAUD, 32'h03);
    $display("t_regs done");
  endtask

  task automatic t_rx;
    bus(1'b1, IDX_CTL1, 32'h01);
    bus(1'b1, IDX_CTL2, 32'h02);
    bus(1'b1, IDX_IMASK, 32'h0A);
    u_peer.send(8'h3C, 32, 1'b0, 1'b0);
    rdchk(IDX_RXST, 32'h40);
    chk(irq, 1'b1);
    rdchk(IDX_RXBUF, 32'h3C);
    rdchk(IDX_RXST, 32'h00);
    bus(1'b1, IDX_IST, 32'h1F);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    $display("t_rx done");
  endtask

  task automatic t_err;
    u_peer.send(8'h3C, 32, 1'b1, 1'b0);
    bus(1'b0, IDX_RXST, 32'h0);
    chk(rd & 32'hBC, 32'h84);
    bus(1'b0, IDX_RXBUF, 32'h0);
    bus(1'b1, IDX_RXST, 32'h3C);
    bus(1'b1, IDX_CTL2, 32'h00);
    bus(1'b1, IDX_IST, 32'h1F);
    u_peer.send(8'h00, 32, 1'b0, 1'b1);
    bus(1'b0, IDX_RXST, 32'h0);
    chk(rd & 32'hA0, 32'hA0);
    bus(1'b0, IDX_IST, 32'h0);
    chk(rd & 32'h0A, 32'h08);
    chk(irq, 1'b1);
    bus(1'b0, IDX_RXBUF, 32'h0);
    bus(1'b1, IDX_RXST, 32'h3C);
    bus(1'b1, IDX_IST, 32'h1F);
    $display("t_err done");
  endtask

  task automatic t_tx;
    logic [10:0] f;
    bus(1'b1, IDX_LBAUD, 32'h0);
    bus(1'b1, IDX_CTL1, 32'h03);
    bus(1'b1, IDX_CTL2, 32'h01);
    fork
      u_peer.get(16, f);
      bus(1'b1, IDX_TXBUF, 32'hA5);
    join
    chk(f, {1'b1, ^8'hA5, 8'hA5, 1'b0});
    rdchk(IDX_CTL2, 32'hC1);
    rdchk(IDX_IST, 32'h11);
    $display("t_tx done");
  endtask

  // Odd parity and two stop bits on tx, then two frames through the rx FIFO
  task automatic t_mode;
    logic [10:0] f;
    bus(1'b1, IDX_CCR, 32'hA7);
    fork
      u_peer.get(16, f);
      bus(1'b1, IDX_TXBUF, 32'hA5);
    join
    chk(f, {1'b1, ~^8'hA5, 8'hA5, 1'b0});
    rdchk(IDX_CTL2, 32'h81);
    bus(1'b1, IDX_FFCT, 32'h01);
    u_peer.send(8'h11, 16, 1'b1, 1'b0);
    u_peer.send(8'h22, 16, 1'b1, 1'b0);
    rdchk(IDX_FFRX, 32'h02);
    bus(1'b0, IDX_RXST, 32'h0);
    chk(rd & 32'hBC, 32'h00);
    rdchk(IDX_RXBUF, 32'h11);
    rdchk(IDX_RXBUF, 32'h22);
    $display("t_mode done");
  endtask

  // Address-bit mode: tx wake frame, rx asleep drops non-address frames
  task automatic t_wake;
    logic [10:0] f;
    bus(1'b1, IDX_CCR, 32'h0F);
    bus(1'b1, IDX_CTL1, 32'h0B);
    fork
      u_peer.get(16, f);
      bus(1'b1, IDX_TXBUF, 32'h5A);
    join
    chk(f, {2'b11, 8'h5A, 1'b0});
    bus(1'b1, IDX_CTL1, 32'h07);
    u_peer.send(8'h33, 16, 1'b0, 1'b0);
    u_peer.send(8'h44, 16, 1'b1, 1'b0);
    rdchk(IDX_FFRX, 32'h01);
    bus(1'b0, IDX_RXST, 32'h0);
    chk(rd & 32'h02, 32'h02);
    rdchk(IDX_RXBUF, 32'h44);
    $display("t_wake done");
  endtask

  // Auto-baud: a 32-clock start bit gives divisor 3
  task automatic t_abd;
    bus(1'b1, IDX_FFCT, 32'h02);
    u_peer.send(8'h41, 32, 1'b1, 1'b0);
    rdchk(IDX_LBAUD, 32'h03);
    rdchk(IDX_FFCT, 32'h82);
    $display("t_abd done");
  endtask

  task automatic test_done;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_rx;
    t_err;
    t_tx;
    t_mode;
    t_wake;
    t_abd;
    test_done;
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    test_done;
  end
endmodule // tb
`default_nettype wire
